// ### rtl/pro_raster_unit.sv
`timescale 1ns/1ps
module pro_raster_unit
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Write-back result
  output logic [15:0] wr_data_o,
  output logic [15:0] wr_enable_o,
  output logic rmw_o
);
  // ----------------------------------------------
  // Registers
  // ----------------------------------------------
  logic [4:0] raster_op_select;
  logic [2:0] pix_size;
  logic trans_en;
  logic reg_src;
  logic unaligned;
  logic [15:0] plane_protect_mask;
  logic [15:0] src_word;
  logic [15:0] dst_word;

  // ----------------------------------------------
  // Bus decode
  // ----------------------------------------------
  wire acc = cyc_i & stb_i & ~ack_o & ~err_o;
  wire hit_ctrl = adr_i == pro_pkg::PRO_OFS_CTRL;
  wire hit_mask = adr_i == pro_pkg::PRO_OFS_MASK;
  wire hit_src = adr_i == pro_pkg::PRO_OFS_SRC;
  wire hit_dst = adr_i == pro_pkg::PRO_OFS_DST;
  wire mapped = hit_ctrl | hit_mask | hit_src | hit_dst;
  wire wr0 = acc & we_i & sel_i[0];
  wire wr1 = acc & we_i & sel_i[1];
  wire [15:0] ctrl_rd = {1'b0, unaligned, reg_src, trans_en, 1'b0, pix_size, 3'h0, raster_op_select};
  wire [15:0] rd_sel = hit_ctrl ? ctrl_rd : hit_mask ? plane_protect_mask : hit_src ? src_word
                       : hit_dst ? dst_word : 16'h0000;

  // Bus handshake, one wait state free answer in next cycle
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= acc & mapped;
      err_o <= acc & ~mapped; // Unmapped address answered with error
      dat_o <= {16'h0000, rd_sel};
    end
  end

  // Control register, op select steers the datapath
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      raster_op_select <= pro_pkg::PRO_RST_OP;
      pix_size <= pro_pkg::PRO_RST_PSZ;
      trans_en <= 1'b0;
      reg_src <= 1'b0;
      unaligned <= 1'b0;
    end
    else
    begin
      if (hit_ctrl && wr0)
        raster_op_select <= dat_i[pro_pkg::PRO_CTRL_OP_LSB +: 5]; // RL5
      if (hit_ctrl && wr1)
      begin
        pix_size <= dat_i[pro_pkg::PRO_CTRL_PSZ_LSB +: 3];
        trans_en <= dat_i[pro_pkg::PRO_CTRL_TRANS_BIT];
        reg_src <= dat_i[pro_pkg::PRO_CTRL_REGSRC_BIT];
        unaligned <= dat_i[pro_pkg::PRO_CTRL_UNALIGN_BIT];
      end
    end
  end

  // Mask and operand words, byte-lane writes
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      plane_protect_mask <= pro_pkg::PRO_RST_MASK;
      src_word <= 16'h0000;
      dst_word <= 16'h0000;
    end
    else
    begin
      if (hit_mask && wr0) plane_protect_mask[7:0] <= dat_i[7:0];
      if (hit_mask && wr1) plane_protect_mask[15:8] <= dat_i[15:8];
      if (hit_src && wr0) src_word[7:0] <= dat_i[7:0];
      if (hit_src && wr1) src_word[15:8] <= dat_i[15:8];
      if (hit_dst && wr0) dst_word[7:0] <= dat_i[7:0];
      if (hit_dst && wr1) dst_word[15:8] <= dat_i[15:8];
    end
  end

  // ----------------------------------------------
  // Operand masking
  // ----------------------------------------------
  // Protected planes read as zero; register sources pass untouched
  wire [15:0] src_m = reg_src ? src_word : (src_word & ~plane_protect_mask); // RL16 RL21 RL22
  wire [15:0] dst_m = dst_word & ~plane_protect_mask; // RL16 RL21

  // ----------------------------------------------
  // Boolean result, bitwise so any pixel size works
  // ----------------------------------------------
  logic [15:0] bool_r;
  always_comb
  begin
    case (raster_op_select[3:0]) // RL1 RL2
      4'h0: bool_r = src_m; // RL6 RL20
      4'h1: bool_r = src_m & dst_m;
      4'h2: bool_r = src_m & ~dst_m;
      4'h3: bool_r = 16'h0000;
      4'h4: bool_r = src_m | ~dst_m; // RL7
      4'h5: bool_r = ~(src_m ^ dst_m);
      4'h6: bool_r = ~dst_m;
      4'h7: bool_r = ~(src_m | dst_m);
      4'h8: bool_r = src_m | dst_m; // RL8
      4'h9: bool_r = dst_m;
      4'ha: bool_r = src_m ^ dst_m;
      4'hb: bool_r = ~src_m & dst_m;
      4'hc: bool_r = 16'hffff; // RL9
      4'hd: bool_r = ~src_m | dst_m;
      4'he: bool_r = ~(src_m & dst_m);
      default: bool_r = ~src_m;
    endcase
  end

  // ----------------------------------------------
  // Arithmetic on 4-bit nibbles, chained per pixel size
  // ----------------------------------------------
  // Carries only cross nibble seams inside one pixel
  wire link1 = pix_size == pro_pkg::PRO_PSZ_8 || pix_size == pro_pkg::PRO_PSZ_16; // RL12 RL24
  wire link2 = pix_size == pro_pkg::PRO_PSZ_16;
  // Bit 0 stays clear: the lowest nibble always starts a pixel
  wire [3:0] chain = {link1, link2, link1, 1'b0}; // Seam into nibble k from k-1
  wire [3:0] msn = {1'b1, ~link1, ~link2, ~link1}; // Nibble ends a pixel
  logic [4:0] add_c;
  logic [4:0] sub_c;
  logic [4:0] cmp_gt;
  logic [4:0] cmp_eq;
  logic [15:0] sum_w;
  logic [15:0] dif_w;
  logic [3:0] ovf;
  logic [3:0] unf;
  logic [3:0] sgt;
  logic [3:0] seq;
  always_comb
  begin
    add_c = 5'h00;
    sub_c = 5'h00;
    sum_w = 16'h0000;
    dif_w = 16'h0000;
    for (int k = 0; k < 4; k++)
    begin
      logic [4:0] s;
      logic [4:0] d;
      logic ci;
      logic bi;
      s = 5'h00;
      d = 5'h00;
      ci = chain[k] & add_c[k];
      bi = chain[k] & sub_c[k];
      s = {1'b0, dst_m[4*k +: 4]} + {1'b0, src_m[4*k +: 4]} + {4'h0, ci}; // RL10 RL3
      d = {1'b0, dst_m[4*k +: 4]} - {1'b0, src_m[4*k +: 4]} - {4'h0, bi};
      sum_w[4*k +: 4] = s[3:0]; // RL11
      dif_w[4*k +: 4] = d[3:0];
      add_c[k+1] = s[4];
      sub_c[k+1] = d[4];
    end
  end

  // Compare nibbles from the top of each pixel downward
  always_comb
  begin
    cmp_gt = 5'h00;
    cmp_eq = 5'h00;
    for (int k = 3; k >= 0; k--)
    begin
      logic gt_hi;
      logic eq_hi;
      gt_hi = msn[k] ? 1'b0 : cmp_gt[k+1];
      eq_hi = msn[k] ? 1'b1 : cmp_eq[k+1];
      cmp_gt[k] = gt_hi | (eq_hi & (src_m[4*k +: 4] > dst_m[4*k +: 4]));
      cmp_eq[k] = eq_hi & (src_m[4*k +: 4] == dst_m[4*k +: 4]);
    end
  end

  // Per-nibble pixel flags, taken from the pixel's end nibbles
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      ovf[k] = 1'b0;
      unf[k] = 1'b0;
      sgt[k] = 1'b0;
      seq[k] = 1'b0;
      for (int j = 0; j < 4; j++)
      begin
        // Pixel top nibble j covers k when no end lies between
        if (j >= k && msn[j] && (j == k || !(|(msn[k +: 1] & 1'b0))))
        begin
          if (j == k || (j > k && !msn[k] && (j - k == 1 || !msn[k + 1]) && (j - k < 3 || !msn[k + 2])))
          begin
            ovf[k] = add_c[j+1];
            unf[k] = sub_c[j+1];
          end
        end
      end
      sgt[k] = cmp_gt[lsn_top(k)];
      seq[k] = cmp_eq[lsn_top(k)];
    end
  end

  // Lowest nibble of the pixel holding nibble k
  function automatic int lsn_top(input int k);
    int b;
    b = k;
    while (b > 0 && chain[b]) b--;
    return b;
  endfunction

  // ----------------------------------------------
  // Arithmetic result select
  // ----------------------------------------------
  logic [15:0] arith_r;
  logic arith_ok;
  always_comb
  begin
    arith_r = dst_m;
    arith_ok = pix_size == pro_pkg::PRO_PSZ_4 || link1; // RL3
    for (int k = 0; k < 4; k++)
    begin
      case (raster_op_select)
        pro_pkg::PRO_OP_ADD: arith_r[4*k +: 4] = sum_w[4*k +: 4];
        pro_pkg::PRO_OP_ADD_SATURATING: arith_r[4*k +: 4] = ovf[k] ? 4'hf : sum_w[4*k +: 4]; // RL13
        pro_pkg::PRO_OP_SUB: arith_r[4*k +: 4] = dif_w[4*k +: 4];
        pro_pkg::PRO_OP_SUBTRACT_SATURATING: arith_r[4*k +: 4] = unf[k] ? 4'h0 : dif_w[4*k +: 4]; // RL14
        pro_pkg::PRO_OP_MAX: arith_r[4*k +: 4] = sgt[k] ? src_m[4*k +: 4] : dst_m[4*k +: 4]; // RL15
        pro_pkg::PRO_OP_MIN: arith_r[4*k +: 4] = (sgt[k] | seq[k]) ? dst_m[4*k +: 4] : src_m[4*k +: 4];
        default: arith_r[4*k +: 4] = dst_m[4*k +: 4]; // RL25
      endcase
    end
  end

  // ----------------------------------------------
  // Result masking, transparency, write enables
  // ----------------------------------------------
  wire is_arith = raster_op_select[4];
  wire reserved = is_arith && (raster_op_select > pro_pkg::PRO_OP_MIN || !arith_ok); // RL25
  wire [15:0] op_r = is_arith ? arith_r : bool_r; // RL4
  wire [15:0] res_m = op_r & ~plane_protect_mask; // RL17
  logic [15:0] opaque;
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      case (pix_size)
        pro_pkg::PRO_PSZ_1: opaque[i] = src_m[i];
        pro_pkg::PRO_PSZ_2: opaque[i] = |src_m[(i/2)*2 +: 2];
        pro_pkg::PRO_PSZ_4: opaque[i] = |src_m[(i/4)*4 +: 4];
        pro_pkg::PRO_PSZ_8: opaque[i] = |src_m[(i/8)*8 +: 8];
        default: opaque[i] = |src_m;
      endcase
    end
  end
  // Transparent pixels and protected planes are held in memory
  wire [15:0] trans_keep = trans_en ? opaque : 16'hffff; // RL23 RL18
  wire [15:0] next_wr_enable = reserved ? 16'h0000 : (trans_keep & ~plane_protect_mask); // RL21
  wire masking = |plane_protect_mask;
  wire next_rmw = ((masking | trans_en) && pix_size != pro_pkg::PRO_PSZ_16) || unaligned; // RL19

  // Registered write-back outputs
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_data_o <= 16'h0000;
      wr_enable_o <= 16'h0000;
      rmw_o <= 1'b0;
    end
    else
    begin
      wr_data_o <= reserved ? dst_word : res_m; // RL18
      wr_enable_o <= next_wr_enable;
      rmw_o <= next_rmw;
    end
  end
endmodule // pro_raster_unit

// ### rtl/pro_pkg.sv
// Overview of operation
// [RL1] Sixteen Boolean and six arithmetic codes
// [RL2] Boolean ops bitwise, all pixel sizes
// [RL3] Arithmetic unsigned, pixel sizes 4/8/16 only
// [RL4] Combine source with destination, write result
// [RL5] Operation taken from control select field
// [RL6] Codes 0-3: copy, AND, AND-not-dst, zeros
// [RL7] Codes 4-7: OR-not-dst, XNOR, not-dst, NOR
// [RL8] Codes 8-b: OR, keep dst, XOR, not-src-AND
// [RL9] Codes c-f: ones, not-src-OR, NAND, not-src
// [RL10] 10000 add, 10010 dst minus src
// [RL11] Plain add/subtract wraps within pixel
// [RL12] No carry between packed pixel fields
// [RL13] Saturating add clamps to all ones
// [RL14] Saturating subtract clamps to zero
// [RL15] Max and min; codes 10110+ reserved
// [RL16] Mask operands from memory before operation
// [RL17] Mask result again after operation
// [RL18] Transparency on masked result, then write
// [RL19] Read-modify-write only when needed
// [RL20] Copy skips combining with destination
// [RL21] Mask one bit: reads zero, write protected
// [RL22] Register sources bypass plane masking
// [RL23] Zero masked source pixel is transparent
// [RL24] All packed pixels processed in one pass
// [RL25] Reserved code leaves destination unchanged
package pro_pkg;
  // ----------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------
  localparam logic [3:0] PRO_OFS_CTRL = 4'h0;
  localparam logic [3:0] PRO_OFS_MASK = 4'h4;
  localparam logic [3:0] PRO_OFS_SRC = 4'h8;
  localparam logic [3:0] PRO_OFS_DST = 4'hc;
  // Control field positions
  localparam int PRO_CTRL_OP_LSB = 0;
  localparam int PRO_CTRL_PSZ_LSB = 8;
  localparam int PRO_CTRL_TRANS_BIT = 12;
  localparam int PRO_CTRL_REGSRC_BIT = 13;
  localparam int PRO_CTRL_UNALIGN_BIT = 14;
  // Reset values
  localparam logic [4:0] PRO_RST_OP = 5'h00;
  localparam logic [2:0] PRO_RST_PSZ = 3'h0;
  localparam logic [15:0] PRO_RST_MASK = 16'h0000;
  // Pixel size codes: 1,2,4,8,16 bits
  localparam logic [2:0] PRO_PSZ_1 = 3'h0;
  localparam logic [2:0] PRO_PSZ_2 = 3'h1;
  localparam logic [2:0] PRO_PSZ_4 = 3'h2;
  localparam logic [2:0] PRO_PSZ_8 = 3'h3;
  localparam logic [2:0] PRO_PSZ_16 = 3'h4;
  // Operation codes
  localparam logic [4:0] PRO_OP_COPY = 5'h00;
  localparam logic [4:0] PRO_OP_AND = 5'h01;
  localparam logic [4:0] PRO_OP_ANDND = 5'h02;
  localparam logic [4:0] PRO_OP_ZERO = 5'h03;
  localparam logic [4:0] PRO_OP_ORND = 5'h04;
  localparam logic [4:0] PRO_OP_XNOR = 5'h05;
  localparam logic [4:0] PRO_OP_NDST = 5'h06;
  localparam logic [4:0] PRO_OP_NOR = 5'h07;
  localparam logic [4:0] PRO_OP_OR = 5'h08;
  localparam logic [4:0] PRO_OP_KEEP = 5'h09;
  localparam logic [4:0] PRO_OP_XOR = 5'h0a;
  localparam logic [4:0] PRO_OP_NSAND = 5'h0b;
  localparam logic [4:0] PRO_OP_ONES = 5'h0c;
  localparam logic [4:0] PRO_OP_NSOR = 5'h0d;
  localparam logic [4:0] PRO_OP_NAND = 5'h0e;
  localparam logic [4:0] PRO_OP_NSRC = 5'h0f;
  localparam logic [4:0] PRO_OP_ADD = 5'h10;
  localparam logic [4:0] PRO_OP_ADD_SATURATING = 5'h11;
  localparam logic [4:0] PRO_OP_SUB = 5'h12;
  localparam logic [4:0] PRO_OP_SUBTRACT_SATURATING = 5'h13;
  localparam logic [4:0] PRO_OP_MAX = 5'h14;
  localparam logic [4:0] PRO_OP_MIN = 5'h15;
endpackage

// ### verification/pro_raster_unit_properties.sv
`timescale 1ns/1ps
// ----
// Port checks
// ----
module pro_raster_unit_properties
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // Result
  input wire logic [15:0] wr_data_o,
  input wire logic [15:0] wr_enable_o,
  input wire logic rmw_o
);
  logic [14:0] hc, hc_d;
  logic [15:0] hm, hm_d;
  logic live;
  wire logic bw = cyc_i && stb_i && we_i && ack_o;
  // Shadow copies; assumes full low-half writes, delayed copy hides the update edge
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      {hc, hc_d, hm, hm_d, live} <= '0;
    else
    begin
      if (bw && adr_i == 4'h0)
        hc <= dat_i[14:0];
      if (bw && adr_i == 4'h4)
        hm <= dat_i[15:0];
      {hc_d, hm_d, live} <= {hc, hm, 1'b1};
    end
  end
  // Settled setup and codes that must not write
  wire logic [2:0] psz = hc[10:8];
  wire logic rsv = hc[4:0] > 5'h15 || (hc[4] && psz < 3'h2);
  wire logic st = live && hc == hc_d && hm == hm_d;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  a_ack_mapped: assert property (s_req ##0 (adr_i[1:0] == 2'h0) |=> ack_o && !err_o)
    else $error("ack missing");
  a_err_unmapped: assert property (s_req ##0 (adr_i[1:0] != 2'h0) |=> err_o && !ack_o)
    else $error("err missing");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_rsv_quiet: assert property (st && rsv |-> wr_enable_o == 16'h0000)
    else $error("reserved code wrote");
  a_mask_keep: assert property (live |-> (wr_enable_o & hm & hm_d) == 16'h0000)
    else $error("protected bit enabled");
  a_full_write: assert property (st && !rsv && hm == 16'h0000 && !hc[12] |-> wr_enable_o == 16'hffff)
    else $error("write incomplete");
  a_rmw_wide: assert property (st && psz == 3'h4 && !hc[14] |-> !rmw_o)
    else $error("needless rmw");
  a_rmw_need: assert property (st && (hc[14] || (psz != 3'h4 && (hm != 16'h0 || hc[12]))) |-> rmw_o)
    else $error("rmw missing");
endmodule // pro_raster_unit_properties
bind pro_raster_unit pro_raster_unit_properties chk_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .wr_data_o(wr_data_o), .wr_enable_o(wr_enable_o), .rmw_o(rmw_o));

// ### verification/pro_mem_model.sv
`timescale 1ns/1ps
// ----
// Destination word in local memory
// ----
module pro_mem_model
(
  // Clock and control
  input wire logic mclk_i,
  input wire logic load_i,
  input wire logic commit_i,
  // Data
  input wire logic [15:0] load_val_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [15:0] wr_enable_i,
  output logic [15:0] mem_o
);
  // Only enabled bits change; the rest keep the old word
  always_ff @(posedge mclk_i)
  begin
    if (load_i)
      mem_o <= load_val_i;
    else if (commit_i)
      mem_o <= (wr_data_i & wr_enable_i) | (mem_o & ~wr_enable_i);
  end
endmodule // pro_mem_model

// ### verification/pro_raster_unit_bench.sv
`timescale 1ns/1ps
module pro_raster_unit_bench;
  // ----
  // Bench signals
  // ----
  logic mclk_i = 0;
  logic rst_b_i = 0;
  logic cyc = 0, stb = 0, we = 0, ld = 0, cm = 0, e;
  logic [3:0] adr = 0, sel = 0;
  logic [31:0] dat = 0, q;
  wire [31:0] rd;
  wire ack, err, rmw;
  wire [15:0] wd, wen, mem;
  int error_cnt = 0, tests_run = 0;
  always #20 mclk_i = ~mclk_i;
  pro_raster_unit dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(rd), .ack_o(ack), .err_o(err), .wr_data_o(wd), .wr_enable_o(wen), .rmw_o(rmw));
  pro_mem_model mem_u (.mclk_i(mclk_i), .load_i(ld), .commit_i(cm), .load_val_i(16'h9c9c), .wr_data_i(wd),
    .wr_enable_i(wen), .mem_o(mem));
  task automatic chk(input logic [16:0] g, input logic [16:0] x);
    tests_run++;
    if (g !== x)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Classic cycle; held until ack or err is sampled, bounded wait
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'h3};
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 40);
    q = rd;
    e = err;
    {cyc, stb} <= 2'b00;
    if (n == 40)
      chk(1, 0);
  endtask
  // Results settle one edge after the write
  task automatic look(input logic [16:0] en, input logic [15:0] dv);
    @(posedge mclk_i);
    #1;
    chk({rmw, wen}, en);
    chk({1'b0, wd}, {1'b0, dv});
  endtask
  function automatic logic [31:0] ctl(logic [4:0] op, logic [2:0] p, logic tr, logic rs, logic ua);
    return {17'h0, ua, rs, tr, 1'b0, p, 3'h0, op};
  endfunction
  // Truth table per Boolean code, indexed by {src, dst}
  function automatic logic [15:0] bref(logic [3:0] op, logic [15:0] s, logic [15:0] d);
    for (int i = 0; i < 16; i++)
      bref[i] = 64'h37bf26ae159d048c >> {op, s[i], d[i]};
  endfunction
  function automatic logic [15:0] aref(logic [4:0] op, logic [15:0] s, logic [15:0] d, int w);
    int a, b, m, r;
    aref = 0;
    m = (1 << w) - 1;
    for (int k = 0; k < 16; k += w)
    begin
      a = (s >> k) & m;
      b = (d >> k) & m;
      case (op)
        5'h10: r = b + a;
        5'h11: r = (a + b > m) ? m : a + b;
        5'h12: r = b - a;
        5'h13: r = (a > b) ? 0 : b - a;
        5'h14: r = (a > b) ? a : b;
        default: r = (a < b) ? a : b;
      endcase
      aref |= 16'((r & m) << k);
    end
  endfunction
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    wb(0, pro_pkg::PRO_OFS_MASK, 0);
    chk({1'b0, q[15:0]}, {1'b0, pro_pkg::PRO_RST_MASK});
    wb(0, 4'h2, 0);
    chk({16'h0, e}, 17'h1);
  endtask
  task automatic t_bool;
    wb(1, 4'h8, 32'hc3a5);
    wb(1, 4'hc, 32'h5f0a);
    for (int p = 0; p < 5; p++)
      for (int op = 0; op < 16; op++)
      begin
        wb(1, 4'h0, ctl(5'(op), 3'(p), 0, 0, 0));
        look(17'h0ffff, bref(4'(op), 16'hc3a5, 16'h5f0a));
      end
  endtask
  // Small pixels and reserved codes leave the destination alone
  task automatic t_arith;
    logic [15:0] s, d;
    logic rsv;
    for (int i = 0; i < 2; i++)
    begin
      s = i ? 16'h1e72 : 16'hf39c;
      d = i ? 16'hf39c : 16'h1e72;
      wb(1, 4'h8, {16'h0, s});
      wb(1, 4'hc, {16'h0, d});
      for (int p = 0; p < 5; p++)
        for (int op = 16; op < 32; op++)
        begin
          rsv = op > 21 || p < 2;
          wb(1, 4'h0, ctl(5'(op), 3'(p), 0, 0, 0));
          look(rsv ? 17'h0 : 17'h0ffff, rsv ? d : aref(5'(op), s, d, 1 << p));
        end
    end
  endtask
  task automatic t_mask;
    wb(1, 4'h4, 32'hf0f0);
    wb(1, 4'h8, 32'h9191);
    wb(1, 4'hc, 32'h0505);
    wb(1, 4'h0, ctl(5'h14, 3, 0, 1, 0));
    look(17'h10f0f, 16'h0101);
    wb(1, 4'h0, ctl(5'h14, 3, 0, 0, 0));
    look(17'h10f0f, 16'h0505);
    wb(1, 4'h0, ctl(5'h14, 4, 0, 0, 0));
    look(17'h00f0f, 16'h0505);
    wb(1, 4'h0, ctl(5'h00, 4, 0, 0, 1));
    look(17'h10f0f, 16'h0101);
    wb(1, 4'h8, 32'h50a3);
    wb(1, 4'h0, ctl(5'h00, 3, 1, 0, 0));
    look(17'h1000f, 16'h0003);
    @(posedge mclk_i);
    ld <= 1;
    @(posedge mclk_i);
    {ld, cm} <= 2'b01;
    @(posedge mclk_i);
    cm <= 0;
    #1;
    chk({1'b0, mem}, 17'h09c93);
  endtask
  // ----
  // Verdict, sequence and watchdog
  // ----
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1;
    t_regs;
    t_bool;
    t_arith;
    t_mask;
    tally_and_finish;
  end
  // Run needs about 1000 cycles; thirty times that is a hang
  initial
  begin
    #1200000;
    error_cnt++;
    tally_and_finish;
  end
endmodule // pro_raster_unit_bench
